//--- hdl/usm_pkg.sv
// Package of constants and types for the synchronous master receive block.
`default_nettype none
package usm_pkg;
  localparam logic [9:0]  IDX_IRQ_FLAGS   = 10'h00c;
  localparam logic [9:0]  IDX_RX_STATUS   = 10'h018;
  localparam logic [9:0]  IDX_RX_DATA     = 10'h01a;
  localparam logic [9:0]  IDX_IRQ_ENABLES = 10'h08c;
  localparam logic [9:0]  IDX_TX_STATUS   = 10'h098;
  localparam logic [9:0]  IDX_BAUD_DIV    = 10'h099;
  localparam int          BIT_RX_FLAG     = 5;
  localparam int          BIT_RX_IRQ_EN   = 5;
  localparam int          BIT_PORT_EN     = 7;
  localparam int          BIT_NINE_EN     = 6;
  localparam int          BIT_SINGLE_EN   = 5;
  localparam int          BIT_CONT_EN     = 4;
  localparam int          BIT_OVERRUN     = 1;
  localparam int          BIT_NINTH       = 0;
  localparam int          BIT_CLK_MASTER  = 7;
  localparam int          BIT_SYNC_MODE   = 4;
  localparam logic [7:0]  RX_STATUS_WMASK = 8'hf0;
  localparam logic [7:0]  TX_STATUS_WMASK = 8'hf5;
  localparam logic [7:0]  TX_STATUS_RO    = 8'h02;
  localparam logic [7:0]  RST_RX_STATUS   = 8'h00;
  localparam logic [7:0]  RST_TX_STATUS   = 8'h02;
  localparam logic [7:0]  RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0]  RST_BAUD_DIV    = 8'h00;
  localparam logic [3:0]  LAST_BIT_8      = 4'h7;
  localparam logic [3:0]  LAST_BIT_9      = 4'h8;
  localparam logic [1:0]  FIFO_DEPTH      = 2'h2;

  typedef struct packed {
    logic active;
    logic single;
    logic cont;
    logic nine;
  } usm_cfg_type;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } usm_word_type;

  typedef enum logic [1:0] {LK_IDLE, LK_SHIFT, LK_WAIT} usm_link_state_type;
endpackage
`default_nettype wire

//--- hdl/usm_rx.sv
// Synchronous master receiver with APB registers and a two-entry receive FIFO.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Reception starts when single or continuous enable is set with the port enabled in synchronous clock-master mode.
// - Incoming data is sampled on the falling edge of the shift clock.
// - Single enable receives exactly one word and then stops.
// - Continuous enable keeps receiving words until software clears it.
// - With both enables set, continuous mode wins.
// - A finished word moves into the FIFO if room, setting the receive flag.
// - Interrupt request only when receive flag and its enable are both set.
// - Receive flag is read-only and clears once the FIFO is read empty.
// - Two words held in the FIFO while a third one shifts in.
// - Word finished with FIFO full sets overrun and is discarded.
// - Overrun is cleared only by software clearing continuous enable.
// - While overrun is set, no word enters the FIFO.
// - Ninth bit buffered per entry; status shows it, read status first.
// - The baud divisor sets the rate of the generated shift clock.
module usm_rx
  import usm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        link_clk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe_b,
  output logic             serial_clk_out,
  output logic             serial_clk_oe_b,
  output logic             receive_irq
);
  logic [7:0]         rx_status;
  logic [7:0]         tx_status;
  logic [7:0]         irq_enables;
  logic [7:0]         baud_div;
  logic               overrun;
  logic               div_tgl;
  usm_word_type       fifo_mem [2];
  logic               wr_ptr;
  logic               rd_ptr;
  logic [1:0]         count;
  logic [2:0]         dn_sync;
  logic               word_evt;
  logic               bus_acc;
  logic               bus_wr;
  logic               status_wr;
  logic               pop;
  logic               push;
  logic               rx_flag;
  logic               addr_ok;
  logic [31:0]        next_prdata;
  usm_cfg_type        cfg;
  logic [1:0]         lk_rst_s;
  logic               lk_rst_b;
  usm_cfg_type        lk_cfg_s1;
  usm_cfg_type        lk_cfg_s2;
  usm_cfg_type        lk_cfg_s3;
  usm_cfg_type        lk_cfg;
  logic [2:0]         lk_div_sync;
  logic [7:0]         lk_div;
  logic [2:0]         lk_din_s;
  logic               lk_din;
  usm_link_state_type lk_state;
  logic [7:0]         lk_cnt;
  logic [3:0]         lk_bit_cnt;
  logic [8:0]         lk_shift;
  logic [8:0]         next_shift;
  logic               lk_sclk;
  logic               lk_done_tgl;
  usm_word_type       lk_word;
  logic               lk_run;
  logic               lk_last;

  assign bus_acc   = psel && penable && pready;
  assign bus_wr    = bus_acc && pwrite && !pslverr;
  assign status_wr = bus_wr && (paddr[11:2] == IDX_RX_STATUS);
  assign rx_flag   = (count != 2'h0);
  assign pop       = bus_acc && !pwrite && (paddr[11:2] == IDX_RX_DATA) && rx_flag;
  assign push      = word_evt && !overrun && (count != FIFO_DEPTH);
  assign word_evt  = dn_sync[2] ^ dn_sync[1];

  always_comb begin
    cfg.active = rx_status[BIT_PORT_EN] && tx_status[BIT_SYNC_MODE]
                 && tx_status[BIT_CLK_MASTER];
    cfg.single = rx_status[BIT_SINGLE_EN];
    cfg.cont   = rx_status[BIT_CONT_EN];
    cfg.nine   = rx_status[BIT_NINE_EN];
  end

  always_comb begin
    addr_ok     = (paddr[1:0] == 2'h0);
    next_prdata = 32'h0;
    unique case (paddr[11:2])
      IDX_IRQ_FLAGS: next_prdata[BIT_RX_FLAG] = rx_flag;
      IDX_RX_STATUS: begin
        next_prdata[7:0]         = rx_status & RX_STATUS_WMASK;
        next_prdata[BIT_OVERRUN] = overrun;
        next_prdata[BIT_NINTH]   = rx_flag && fifo_mem[rd_ptr].ninth;
      end
      IDX_RX_DATA: next_prdata[7:0] = rx_flag ? fifo_mem[rd_ptr].data : 8'h00;
      IDX_IRQ_ENABLES: next_prdata[7:0] = irq_enables;
      IDX_TX_STATUS: next_prdata[7:0] = tx_status | TX_STATUS_RO;
      IDX_BAUD_DIV: next_prdata[7:0] = baud_div;
      default: addr_ok = 1'b0;
    endcase
  end

  // Answer is registered in the setup cycle, so every access has no wait state.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= (psel && !penable && !pwrite && addr_ok) ? next_prdata : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_status   <= RST_TX_STATUS;
      irq_enables <= RST_IRQ_ENABLES;
      baud_div    <= RST_BAUD_DIV;
      div_tgl     <= 1'b0;
    end else if (bus_wr) begin
      if (paddr[11:2] == IDX_TX_STATUS) begin
        tx_status <= (pwdata[7:0] & TX_STATUS_WMASK) | TX_STATUS_RO;
      end
      if (paddr[11:2] == IDX_IRQ_ENABLES) begin
        irq_enables <= pwdata[7:0];
      end
      if (paddr[11:2] == IDX_BAUD_DIV) begin
        baud_div <= pwdata[7:0];
        div_tgl  <= !div_tgl;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_status <= RST_RX_STATUS;
    end else if (status_wr) begin
      rx_status <= pwdata[7:0] & RX_STATUS_WMASK;
    end else if (word_evt && !rx_status[BIT_CONT_EN]) begin
      rx_status[BIT_SINGLE_EN] <= 1'b0;
    end
  end

  // A late overrun wins over a clear written in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      overrun <= 1'b0;
    end else if (word_evt && !overrun && (count == FIFO_DEPTH)) begin
      overrun <= 1'b1;
    end else if (status_wr && !pwdata[BIT_CONT_EN]) begin
      overrun <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wr_ptr] <= lk_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      receive_irq <= 1'b0;
    end else begin
      receive_irq <= rx_flag && irq_enables[BIT_RX_IRQ_EN];
    end
  end

  // The held word is stable for a whole word time, far longer than this sync.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dn_sync <= 3'h0;
    end else begin
      dn_sync <= {dn_sync[1:0], lk_done_tgl};
    end
  end

  always_ff @(posedge link_clk) begin
    lk_rst_s <= {lk_rst_s[0], rst_b};
  end
  assign lk_rst_b = lk_rst_s[1];

  always_ff @(posedge link_clk) begin
    if (!lk_rst_b) begin
      lk_cfg_s1   <= '0;
      lk_cfg_s2   <= '0;
      lk_cfg_s3   <= '0;
      lk_cfg      <= '0;
      lk_div_sync <= 3'h0;
      lk_div      <= RST_BAUD_DIV;
      lk_din_s    <= 3'h0;
      lk_din      <= 1'b0;
    end else begin
      lk_cfg_s1   <= cfg;
      lk_cfg_s2   <= lk_cfg_s1;
      lk_cfg_s3   <= lk_cfg_s2;
      lk_div_sync <= {lk_div_sync[1:0], div_tgl};
      lk_din_s    <= {lk_din_s[1:0], serial_data_in};
      if (lk_cfg_s2 == lk_cfg_s3) begin
        lk_cfg <= lk_cfg_s3;
      end
      // Divisor word is quasi-static once its toggle has crossed.
      if (lk_div_sync[2] ^ lk_div_sync[1]) begin
        lk_div <= baud_div;
      end
      if (lk_din_s[2] == lk_din_s[1]) begin
        lk_din <= lk_din_s[2];
      end
    end
  end

  assign lk_run  = lk_cfg.active && (lk_cfg.single || lk_cfg.cont);
  assign lk_last = lk_bit_cnt == (lk_cfg.nine ? LAST_BIT_9 : LAST_BIT_8);

  always_comb begin
    next_shift = lk_shift;
    next_shift[lk_bit_cnt[3] ? 4'h8 : lk_bit_cnt] = lk_din;
  end

  always_ff @(posedge link_clk) begin
    if (!lk_rst_b) begin
      lk_state    <= LK_IDLE;
      lk_cnt      <= 8'h00;
      lk_bit_cnt  <= 4'h0;
      lk_shift    <= 9'h000;
      lk_sclk     <= 1'b0;
      lk_done_tgl <= 1'b0;
      lk_word     <= '0;
    end else begin
      unique case (lk_state)
        LK_IDLE: begin
          lk_sclk    <= 1'b0;
          lk_cnt     <= 8'h00;
          lk_bit_cnt <= 4'h0;
          if (lk_run) begin
            lk_state <= LK_SHIFT;
          end
        end
        LK_SHIFT: begin
          if (!lk_run) begin
            lk_state <= LK_IDLE;
            lk_sclk  <= 1'b0;
          end else if (lk_cnt == lk_div) begin
            lk_cnt  <= 8'h00;
            lk_sclk <= !lk_sclk;
            if (lk_sclk) begin
              lk_shift   <= next_shift;
              lk_bit_cnt <= lk_last ? 4'h0 : lk_bit_cnt + 4'h1;
              if (lk_last) begin
                lk_word.data  <= next_shift[7:0];
                lk_word.ninth <= lk_cfg.nine && next_shift[8];
                lk_done_tgl   <= !lk_done_tgl;
                lk_state      <= lk_cfg.cont ? LK_SHIFT : LK_WAIT;
              end
            end
          end else begin
            lk_cnt <= lk_cnt + 8'h01;
          end
        end
        LK_WAIT: begin
          lk_sclk <= 1'b0;
          if (lk_cfg.active && lk_cfg.cont) begin
            lk_state <= LK_SHIFT;
          end else if (!lk_run) begin
            lk_state <= LK_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lk_rst_b) begin
      serial_clk_out   <= 1'b0;
      serial_clk_oe_b  <= 1'b1;
      serial_data_out  <= 1'b0;
      serial_data_oe_b <= 1'b1;
    end else begin
      serial_clk_out   <= lk_sclk;
      serial_clk_oe_b  <= !lk_run;
      serial_data_out  <= 1'b0;
      serial_data_oe_b <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_irq_gate: assert property (receive_irq == $past(rx_flag && irq_enables[BIT_RX_IRQ_EN]))
    else $error("receive irq does not follow flag and enable");
  chk_flag_clear: assert property (pop && !push && count == 2'h1 |=> !rx_flag)
    else $error("receive flag stays after last read");
  chk_fifo_depth: assert property (count <= FIFO_DEPTH)
    else $error("fifo count above two");
  chk_overrun_set: assert property (word_evt && !overrun && count == 2'h2 |=> overrun)
    else $error("overrun not set on full fifo");
  chk_overrun_clr: assert property (status_wr && !pwdata[BIT_CONT_EN] && !word_evt |=> !overrun)
    else $error("overrun not cleared by continuous clear");
  chk_overrun_block: assert property (overrun && word_evt |=> count <= $past(count))
    else $error("word entered fifo during overrun");
  chk_word_push: assert property (word_evt && !overrun && count < 2'h2 && !pop |=> count == $past(count) + 2'h1)
    else $error("finished word not stored");
  chk_single_stop: assert property (word_evt && !rx_status[BIT_CONT_EN] && !status_wr |=> !rx_status[BIT_SINGLE_EN])
    else $error("single enable not cleared after word");
  chk_sample_edge: assert property (@(posedge link_clk) disable iff (!lk_rst_b) $past(lk_state) == LK_SHIFT && lk_bit_cnt != $past(lk_bit_cnt) |-> $fell(lk_sclk))
    else $error("bit taken outside falling edge");
  chk_baud_period: assert property (@(posedge link_clk) disable iff (!lk_rst_b) lk_state == LK_SHIFT && lk_run && lk_cnt != lk_div |=> $stable(lk_sclk))
    else $error("shift clock toggled before divisor count");
  chk_cont_prio: assert property (@(posedge link_clk) disable iff (!lk_rst_b) lk_state == LK_WAIT && lk_cfg.active && lk_cfg.cont |=> lk_state == LK_SHIFT)
    else $error("continuous mode not resumed");
  chk_start_rx: assert property (@(posedge link_clk) disable iff (!lk_rst_b) lk_state == LK_IDLE && lk_run |=> lk_state == LK_SHIFT)
    else $error("reception did not start");
  chk_clk_drive: assert property (@(posedge link_clk) disable iff (!lk_rst_b) !lk_run |=> serial_clk_oe_b)
    else $error("shift clock driven while disabled");

  cov_word_push: cover property (push);
  cov_fifo_full: cover property (count == 2'h2);
  cov_overrun: cover property (word_evt && count == 2'h2);
  cov_pop_empty: cover property (pop && count == 2'h1);
endmodule // usm_rx
`default_nettype wire

//--- verif/usm_slave_model.sv
// Serial slave model that shifts words onto the shared data pin.
`timescale 1ns/1ps
`default_nettype none
module usm_slave_model
  import usm_pkg::*;
(
  input  wire logic serial_clk,
  input  wire logic serial_clk_oe_b,
  input  wire logic nine,
  output logic      serial_data
);
  usm_word_type q[$];
  usm_word_type cur;
  int           bitn;
  initial begin
    serial_data = 1'b1;
    bitn        = 0;
    cur         = '0;
  end
  // The bit changes on the rise so it is settled at the sampling fall.
  always @(posedge serial_clk) begin
    if (bitn == 0) begin
      cur = (q.size() > 0) ? q.pop_front() : usm_word_type'($urandom);
    end
    serial_data <= (bitn == 8) ? cur.ninth : cur.data[bitn];
    bitn = (bitn == (nine ? 8 : 7)) ? 0 : bitn + 1;
  end
  // A released clock ends the frame, so the stale bit is not left on the line.
  always @(posedge serial_clk_oe_b) begin
    bitn = 0;
    serial_data <= ~serial_data;
  end
endmodule // usm_slave_model
`default_nettype wire

//--- verif/test_usm_rx.sv
// Self-checking bench for the synchronous master receive block.
`timescale 1ns/1ps
`default_nettype none
module test_usm_rx;
  import usm_pkg::*;
  logic         clk = 1'b0;
  logic         link_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0;
  logic         nine = 1'b0;
  logic [31:0]  prdata;
  logic         pready, pslverr, sd_in, sd_out, sd_oe_b, sclk, sclk_oe_b, receive_irq;
  logic [33:0]  notes[$];
  logic [33:0]  n;
  usm_word_type w[3];
  int           errors = 0;
  int           checked = 0;
  int           cycles = 0;
  time          t0;
  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  usm_rx u_dut (.clk(clk), .rst_b(rst_b), .link_clk(link_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_data_in(sd_in), .serial_data_out(sd_out),
    .serial_data_oe_b(sd_oe_b), .serial_clk_out(sclk), .serial_clk_oe_b(sclk_oe_b),
    .receive_irq(receive_irq));
  usm_slave_model u_slave (.serial_clk(sclk), .serial_clk_oe_b(sclk_oe_b), .nine(nine),
    .serial_data(sd_in));
  task automatic results();
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] d,
                     input logic err = 1'b0, input logic [1:0] lo = 2'b00);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, lo};
    pwdata <= {24'h0, d};
    notes.push_back({wr, err, err ? 32'h0 : {24'h0, d}});
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 2000 && receive_irq !== 1'b1; i++) @(posedge clk);
    check("receive_irq", 32'h1, {31'h0, receive_irq});
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      n = (notes.size() > 0) ? notes.pop_front() : '1;
      check("pslverr", {31'h0, n[32]}, {31'h0, pslverr});
      if (!n[33]) begin
        check("prdata", n[31:0], prdata);
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      results();
    end
  end
  initial begin
    void'($urandom(45573));
    for (int k = 0; k < 3; k++) w[k] = usm_word_type'($urandom);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    apb(IDX_IRQ_FLAGS, 0, 8'h00);
    apb(IDX_RX_STATUS, 0, RST_RX_STATUS);
    apb(IDX_RX_DATA, 0, 8'h00);
    apb(IDX_IRQ_ENABLES, 0, RST_IRQ_ENABLES);
    apb(IDX_TX_STATUS, 0, RST_TX_STATUS);
    apb(IDX_BAUD_DIV, 0, RST_BAUD_DIV);
    apb(10'h001, 1, 8'hff, 1'b1);
    apb(10'h001, 0, 8'h00, 1'b1);
    // Misaligned access to a mapped word is refused and its write is dropped.
    apb(IDX_BAUD_DIV, 1, 8'h33, 1'b1, 2'h2);
    apb(IDX_BAUD_DIV, 0, 8'h00, 1'b1, 2'h1);
    apb(IDX_BAUD_DIV, 0, RST_BAUD_DIV);
    apb(IDX_IRQ_FLAGS, 1, 8'hff);
    apb(IDX_IRQ_FLAGS, 0, 8'h00);
    check("clk_oe_b", 32'h1, {31'h0, sclk_oe_b});
    apb(IDX_BAUD_DIV, 1, 8'h05);
    apb(IDX_TX_STATUS, 1, 8'h90);
    apb(IDX_TX_STATUS, 0, 8'h92);
    apb(IDX_IRQ_ENABLES, 1, 8'h20);
    apb(IDX_RX_STATUS, 1, 8'h80);
    repeat (20) @(posedge clk);
    u_slave.q.push_back(w[0]);
    apb(IDX_RX_STATUS, 1, 8'ha0);
    @(posedge sclk);
    t0 = $time;
    @(posedge sclk);
    check("clk_period", 32'd360, 32'($time - t0));
    check("clk_oe_b", 32'h0, {31'h0, sclk_oe_b});
    check("data_oe_b", 32'h1, {31'h0, sd_oe_b});
    check("data_out", 32'h0, {31'h0, sd_out});
    wait_irq();
    apb(IDX_RX_STATUS, 0, 8'h80);
    apb(IDX_RX_DATA, 0, w[0].data);
    apb(IDX_IRQ_FLAGS, 0, 8'h00);
    check("receive_irq", 32'h0, {31'h0, receive_irq});
    repeat (300) @(posedge clk);
    apb(IDX_IRQ_FLAGS, 0, 8'h00);
    u_slave.q.push_back(w[1]);
    u_slave.q.push_back(w[2]);
    apb(IDX_RX_STATUS, 1, 8'hb0);
    wait_irq();
    repeat (200) @(posedge clk);
    apb(IDX_RX_STATUS, 1, 8'h80);
    apb(IDX_RX_DATA, 0, w[1].data);
    apb(IDX_RX_DATA, 0, w[2].data);
    apb(IDX_IRQ_ENABLES, 1, 8'h00);
    nine <= 1'b1;
    u_slave.q.push_back(w[0]);
    u_slave.q.push_back(w[1]);
    apb(IDX_RX_STATUS, 1, 8'hd0);
    repeat (700) @(posedge clk);
    check("receive_irq", 32'h0, {31'h0, receive_irq});
    apb(IDX_IRQ_FLAGS, 0, 8'h20);
    apb(IDX_IRQ_ENABLES, 1, 8'h20);
    repeat (2) @(posedge clk);
    check("receive_irq", 32'h1, {31'h0, receive_irq});
    apb(IDX_RX_STATUS, 0, 8'hd2 | {7'h0, w[0].ninth});
    apb(IDX_RX_DATA, 0, w[0].data);
    apb(IDX_RX_STATUS, 0, 8'hd2 | {7'h0, w[1].ninth});
    apb(IDX_RX_DATA, 0, w[1].data);
    apb(IDX_IRQ_FLAGS, 0, 8'h00);
    apb(IDX_RX_STATUS, 1, 8'hc0);
    apb(IDX_RX_STATUS, 0, 8'hc0);
    results();
  end
endmodule // test_usm_rx
`default_nettype wire
